/* File: cic_pkg.sv */
// Package of constants and types for the contact input control block
package cic_pkg;

  // Clock rate and derived one-second tick
  localparam int unsigned CIC_CLK_HZ = 25_000_000;
  localparam int unsigned CIC_TICK_S = 1;
  localparam int unsigned CIC_TICK_CYC = CIC_CLK_HZ * CIC_TICK_S;
  // Least hold time of a pulse-toggle input, for reference
  localparam int unsigned CIC_PULSE_HOLD_MS = 300;

  // Register byte offsets
  localparam logic [7:0] CIC_OFS_CFG = 8'h00;
  localparam logic [7:0] CIC_OFS_TIME = 8'h04;
  localparam logic [7:0] CIC_OFS_STAT = 8'h08;
  localparam logic [7:0] CIC_OFS_IRQ = 8'h0C;
  localparam logic [7:0] CIC_OFS_MASK = 8'h10;

  // CFG field positions
  localparam int CIC_CFG_FN1 = 0;  // 3 bits
  localparam int CIC_CFG_FN2 = 4;  // 3 bits
  localparam int CIC_CFG_RESP = 8; // 2 bits
  localparam int CIC_CFG_MODE = 12; // 3 bits
  // TIME field positions
  localparam int CIC_TIME_DLY = 0;  // 16 bits
  localparam int CIC_TIME_OFF = 16; // 16 bits

  // Reset values
  localparam logic [31:0] CIC_CFG_RST = 32'h0000_0001;
  localparam logic [31:0] CIC_TIME_RST = 32'h0000_0000;
  localparam logic [1:0] CIC_IRQ_RST = 2'h0;

  // Input function codes
  typedef enum logic [2:0] {
    FN_OFF = 3'h0,
    FN_RUN_LEVEL = 3'h1,
    FN_RUN_PULSE = 3'h2,
    FN_SW_NO = 3'h3,
    FN_SW_NC = 3'h4,
    FN_HOST_LEVEL = 3'h5,
    FN_HOST_PULSE = 3'h6
  } cic_fn_t;

  // Alarm response codes
  typedef enum logic [1:0] {
    RESP_STOP = 2'h0,
    RESP_CONTINUE = 2'h1,
    RESP_IGNORE = 2'h2
  } cic_resp_t;

  // Communication mode codes
  typedef enum logic [2:0] {
    MODE_LOCAL = 3'h0,
    MODE_CONTACT = 3'h1,
    MODE_MODBUS = 3'h2,
    MODE_SIMPLE1 = 3'h3,
    MODE_SIMPLE2 = 3'h4
  } cic_mode_t;

  // Supervision state of one switch
  typedef enum logic [1:0] {
    SV_IDLE,
    SV_DELAY,
    SV_WATCH,
    SV_FAULT
  } cic_sv_t;

endpackage : cic_pkg

/* File: cic_sup_if.sv */
// Interface joining the control block to one switch supervisor
`timescale 1ns/10ps
interface cic_sup_if;
  logic enable;
  logic start;
  logic tick;
  logic healthy;
  logic [15:0] delay_s;
  logic [15:0] off_s;
  logic fault;
  modport ctrl (output enable, start, tick, healthy, delay_s, off_s,
                input fault);
  modport sup (input enable, start, tick, healthy, delay_s, off_s,
               output fault);
endinterface : cic_sup_if

/* File: cic_sup.sv */
// Supervisor of one external switch with read delay and OFF timers
`timescale 1ns/10ps
module cic_sup
  import cic_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  cic_sup_if.sup sup
);

  typedef struct packed {
    cic_sv_t st;
    logic [15:0] cnt;
  } cic_sup_state_t;

  cic_sup_state_t s;
  cic_sup_state_t next_s;

  // Delay, then watch for a continuously open switch
  always_comb begin
    next_s = s;
    if (!sup.enable) begin
      next_s.st = SV_IDLE;
      next_s.cnt = 16'h0000;
    end else if (sup.start) begin
      next_s.st = SV_DELAY;
      next_s.cnt = 16'h0000;
    end else begin
      unique case (s.st)
        SV_IDLE: begin
          next_s.cnt = 16'h0000;
        end
        SV_DELAY: begin
          if (s.cnt >= sup.delay_s) begin
            next_s.st = SV_WATCH;
            next_s.cnt = 16'h0000;
          end else if (sup.tick) begin
            next_s.cnt = s.cnt + 16'h0001;
          end
        end
        SV_WATCH: begin
          if (sup.healthy) begin
            next_s.cnt = 16'h0000;
          end else if (s.cnt >= sup.off_s) begin
            next_s.st = SV_FAULT;
          end else if (sup.tick) begin
            next_s.cnt = s.cnt + 16'h0001;
          end
        end
        SV_FAULT: begin
          next_s.cnt = s.cnt;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '{st: SV_IDLE, cnt: 16'h0000};
    end else begin
      s <= next_s;
    end
  end

  assign sup.fault = (s.st == SV_FAULT);

endmodule : cic_sup

/* File: cic_top.sv */
// Contact input control with AXI4-Lite registers and interrupt
`timescale 1ns/10ps

// Behaviour
// - Two configurable inputs; default input one level run, input two unused
// - Level run: operate while input asserted, stop when deasserted
// - Pulse run: on release edge start if stopped, stop if running
// - Level host select: contact control active while input asserted
// - Pulse host select: toggle idle and active on each release edge
// - Supervision begins only after read delay from start; default zero
// - Switch fails only after continuously open for OFF time; default zero
// - Input two switch open raises its fault, stopping operation by default
// - Fault response: stop, continue, or do not detect
// - Run deasserted stops; later switch opening raises no fault
// - Supervision suspended whenever product not operating
// - Switch one supervised only local, MODBUS, pattern 1; switch two always
// - With both supervised, either fault raises alarm; stops only under the stop response
// - Each switch selectable normally open or normally closed
// - No function on either input: contacts ignored for control
// - Host select on either input: no product control from contacts
module cic_top
  import cic_pkg::*;
#(
  parameter int unsigned TICK_CYC = CIC_TICK_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_contact1,
  input wire logic i_contact2,
  input wire logic i_other_run_req,
  input wire logic i_other_stop_req,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic o_running,
  output logic o_contact_control_active,
  output logic o_input_two_switch_fault,
  output logic o_switch_fault,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] tim;
    logic [1:0] irq;
    logic [1:0] mask;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] tick_cnt;
    logic tick;
    logic in1_q;
    logic in2_q;
    logic running;
    logic halted;
    logic host_active;
    logic start;
    logic fault1;
    logic fault2;
    logic run_o;
    logic host_o;
    logic f2_o;
    logic f_o;
  } cic_state_t;

  cic_state_t s;
  cic_state_t next_s;

  cic_sup_if sup1 ();
  cic_sup_if sup2 ();

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Whether one function code is a switch supervision function
  function automatic logic is_sw(input logic [2:0] fn);
    return (fn == FN_SW_NO) || (fn == FN_SW_NC);
  endfunction

  // Healthy level of a switch for its polarity
  function automatic logic sw_ok(input logic [2:0] fn, input logic lvl);
    return (fn == FN_SW_NC) ? !lvl : lvl;
  endfunction

  // ----------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------
  logic [2:0] fn1;
  logic [2:0] fn2;
  logic [1:0] resp;
  logic [2:0] mode;
  logic host_sel;
  logic sw1_mode_ok;
  logic mon1;
  logic mon2;
  logic fault_any;
  logic w_fire;
  logic [7:0] rd_addr;

  assign fn1 = s.cfg[CIC_CFG_FN1 +: 3];
  assign fn2 = s.cfg[CIC_CFG_FN2 +: 3];
  assign resp = s.cfg[CIC_CFG_RESP +: 2];
  assign mode = s.cfg[CIC_CFG_MODE +: 3];
  assign host_sel = (fn1 == FN_HOST_LEVEL) || (fn1 == FN_HOST_PULSE) ||
                    (fn2 == FN_HOST_LEVEL) || (fn2 == FN_HOST_PULSE);
  // Switch one only outside contact control and pattern 2 modes
  assign sw1_mode_ok = (mode == MODE_LOCAL) || (mode == MODE_MODBUS) ||
                       (mode == MODE_SIMPLE1);
  assign mon1 = is_sw(fn1) && sw1_mode_ok && (resp != RESP_IGNORE);
  assign mon2 = is_sw(fn2) && (resp != RESP_IGNORE);

  // Supervisor connections
  assign sup1.enable = s.running && mon1;
  assign sup1.start = s.start;
  assign sup1.tick = s.tick;
  assign sup1.healthy = sw_ok(fn1, s.in1_q);
  assign sup1.delay_s = s.tim[CIC_TIME_DLY +: 16];
  assign sup1.off_s = s.tim[CIC_TIME_OFF +: 16];
  assign sup2.enable = s.running && mon2;
  assign sup2.start = s.start;
  assign sup2.tick = s.tick;
  assign sup2.healthy = sw_ok(fn2, s.in2_q);
  assign sup2.delay_s = s.tim[CIC_TIME_DLY +: 16];
  assign sup2.off_s = s.tim[CIC_TIME_OFF +: 16];

  cic_sup u_sup1 (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .sup(sup1)
  );

  cic_sup u_sup2 (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .sup(sup2)
  );

  assign fault_any = sup1.fault || sup2.fault;
  assign w_fire = s.aw_got && s.w_got && !s.bvalid;
  assign rd_addr = s_axi_araddr[7:0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic rel1;
    logic rel2;
    logic run_lvl;
    logic run_pulse;
    logic want_run;
    rel1 = 1'b0;
    rel2 = 1'b0;
    run_lvl = 1'b0;
    run_pulse = 1'b0;
    want_run = 1'b0;
    next_s = s;

    // Seconds tick
    next_s.tick = 1'b0;
    if (s.tick_cnt >= TICK_CYC - 1) begin
      next_s.tick_cnt = 32'h0000_0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 32'h0000_0001;
    end

    // Input history and release edges
    next_s.in1_q = i_contact1;
    next_s.in2_q = i_contact2;
    rel1 = s.in1_q && !i_contact1;
    rel2 = s.in2_q && !i_contact2;

    // Host select state
    if (fn1 == FN_HOST_LEVEL) begin
      next_s.host_active = i_contact1;
    end else if (fn2 == FN_HOST_LEVEL) begin
      next_s.host_active = i_contact2;
    end else if ((fn1 == FN_HOST_PULSE && rel1) ||
                 (fn2 == FN_HOST_PULSE && rel2)) begin
      next_s.host_active = !s.host_active;
    end else if (!host_sel) begin
      next_s.host_active = 1'b0;
    end

    // Run control from contacts, or from elsewhere under host select or when no run function assigned
    next_s.start = 1'b0;
    want_run = s.running;
    if (host_sel) begin
      want_run = s.running;
      if (i_other_run_req) want_run = 1'b1;
      if (i_other_stop_req) want_run = 1'b0;
    end else begin
      run_lvl = (fn1 == FN_RUN_LEVEL) || (fn2 == FN_RUN_LEVEL);
      run_pulse = (fn1 == FN_RUN_PULSE) || (fn2 == FN_RUN_PULSE);
      if (fn1 == FN_RUN_LEVEL) begin
        want_run = i_contact1;
      end else if (fn2 == FN_RUN_LEVEL) begin
        want_run = i_contact2;
      end else if ((fn1 == FN_RUN_PULSE && rel1) ||
                   (fn2 == FN_RUN_PULSE && rel2)) begin
        want_run = !s.running;
      end else if (!run_lvl && !run_pulse) begin
        // No contact run function: other requests steer
        if (i_other_run_req) want_run = 1'b1;
        if (i_other_stop_req) want_run = 1'b0;
      end
    end
    // Stopping fault halts and blocks restart until request withdrawn
    if (fault_any && resp == RESP_STOP && s.running) begin
      next_s.halted = 1'b1;
    end else if (!want_run) begin
      next_s.halted = 1'b0;
    end
    if (next_s.halted) begin
      want_run = 1'b0;
    end
    // Stop always ends supervision first, so no later fault
    next_s.running = want_run;
    if (want_run && !s.running) begin
      next_s.start = 1'b1;
    end
    next_s.fault1 = sup1.fault;
    next_s.fault2 = sup2.fault;

    // Sticky interrupts, set wins over clear
    if (w_fire && s.aw_addr == CIC_OFS_IRQ && s.w_strb[0]) begin
      next_s.irq = s.irq & ~s.w_data[1:0];
    end
    if (sup2.fault && !s.fault2) next_s.irq[1] = 1'b1;
    if (fault_any && !(s.fault1 || s.fault2)) next_s.irq[0] = 1'b1;

    // Write channel capture
    if (!s.aw_got && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr[7:0];
    end
    if (!s.w_got && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (w_fire) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = 2'b00;
      unique case (s.aw_addr)
        CIC_OFS_CFG: next_s.cfg = merge(s.cfg, s.w_data, s.w_strb);
        CIC_OFS_TIME: next_s.tim = merge(s.tim, s.w_data, s.w_strb);
        CIC_OFS_STAT: next_s.bresp = 2'b10;
        CIC_OFS_IRQ: next_s.bresp = 2'b00;
        CIC_OFS_MASK: begin
          if (s.w_strb[0]) next_s.mask = s.w_data[1:0];
        end
        default: next_s.bresp = 2'b10;
      endcase
    end
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;

    // Read channel
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    if (!s.rvalid && s_axi_arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = 2'b00;
      next_s.rdata = 32'h0000_0000;
      unique case (rd_addr)
        CIC_OFS_CFG: next_s.rdata = s.cfg;
        CIC_OFS_TIME: next_s.rdata = s.tim;
        CIC_OFS_STAT: next_s.rdata = {28'h000_0000, sup2.fault,
                                      sup1.fault, s.host_active, s.running};
        CIC_OFS_IRQ: next_s.rdata = {30'h0000_0000, s.irq};
        CIC_OFS_MASK: next_s.rdata = {30'h0000_0000, s.mask};
        default: next_s.rresp = 2'b10;
      endcase
    end

    // Registered outputs
    next_s.run_o = next_s.running;
    next_s.host_o = next_s.host_active;
    next_s.f2_o = sup2.fault;
    next_s.f_o = fault_any;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
      s.cfg <= CIC_CFG_RST;
      s.tim <= CIC_TIME_RST;
      s.irq <= CIC_IRQ_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign s_axi_awready = !s.aw_got;
  assign s_axi_wready = !s.w_got;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign o_running = s.run_o;
  assign o_contact_control_active = s.host_o;
  assign o_input_two_switch_fault = s.f2_o;
  assign o_switch_fault = s.f_o;
  assign o_irq = |(s.irq & s.mask);

endmodule : cic_top

/* File: cic_checker.sv */
// Port checker for the contact input control block
`timescale 1ns/10ps
module cic_checker
  import cic_pkg::*;
#(
  parameter int unsigned TICK_CYC = 10
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic o_running,
  input wire logic o_input_two_switch_fault,
  input wire logic o_switch_fault
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  // Switch two fault only within any fault; fault outputs rise only from operation and clear within three stopped cycles
  a_sw2_in_any: assert property (
    o_input_two_switch_fault |-> o_switch_fault)
    else $error("switch two fault outside any fault");
  a_fault_needs_run: assert property (
    $rose(o_switch_fault) |-> $past(o_running))
    else $error("fault raised while stopped");
  a_sw2_needs_run: assert property (
    $rose(o_input_two_switch_fault) |-> $past(o_running))
    else $error("switch two fault raised while stopped");
  a_fault_clear_stop: assert property (
    !o_running [*3] |-> !o_switch_fault)
    else $error("fault kept after stop");
  // Bus answers and their holding
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule // cic_checker

bind cic_top cic_checker #(.TICK_CYC(TICK_CYC)) u_checker (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .o_running(o_running),
  .o_input_two_switch_fault(o_input_two_switch_fault),
  .o_switch_fault(o_switch_fault)
);

/* File: cic_partner.sv */
// Model of the customer's contact switches and control equipment
`timescale 1ns/10ps
module cic_partner #(
  parameter int HOLD_CYC = 8
) (
  input wire logic i_sys_clk,
  output logic o_contact1,
  output logic o_contact2
);
  // Contacts open at power-up
  initial begin
    o_contact1 = 1'h0;
    o_contact2 = 1'h0;
  end
  // Set one contact level just after an edge
  task automatic drive(input int idx, input bit lvl);
    @(posedge i_sys_clk);
    if (idx == 1) o_contact1 <= lvl;
    else o_contact2 <= lvl;
  endtask
  // Close, hold a scaled-down minimum, then release
  task automatic press(input int idx);
    drive(idx, 1'h1);
    repeat (HOLD_CYC) @(posedge i_sys_clk);
    drive(idx, 1'h0);
  endtask
endmodule // cic_partner

/* File: test_contact_input_control.sv */
// Self-checking testbench of the contact input control block
`timescale 1ns/10ps
module test_contact_input_control;
  import cic_pkg::*;
  localparam int TK = 10;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic run_req = 1'h0;
  logic stop_req = 1'h0;
  logic c1, c2, awready, wready, bvalid, arready, rvalid;
  logic run, cca, f2, fany, irq;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  int err_count = 0;
  int compares = 0;

  always #20 clk = ~clk;

  cic_top #(.TICK_CYC(TK)) dut (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_contact1(c1), .i_contact2(c2),
    .i_other_run_req(run_req), .i_other_stop_req(stop_req),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .o_running(run),
    .o_contact_control_active(cca), .o_input_two_switch_fault(f2),
    .o_switch_fault(fany), .o_irq(irq));

  cic_partner #(.HOLD_CYC(8)) far (
    .i_sys_clk(clk), .o_contact1(c1), .o_contact2(c2));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Register write, response taken a cycle late
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1 && bready !== 1'h1) bready <= 1'h1;
    end while (!(bvalid === 1'h1 && bready === 1'h1));
    r = bresp;
    bready <= 1'h0;
  endtask

  // Register read, data taken a cycle late
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1 && rready !== 1'h1) rready <= 1'h1;
    end while (!(rvalid === 1'h1 && rready === 1'h1));
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  // One supervised run against the reference model
  task automatic sup(input int f1, f2c, rs, md, input bit ok1, ok2);
    int d, o, n, first;
    bit s1, s2, fa, seen, drop, seen2;
    logic [1:0] m, r;
    logic [31:0] v;
    d = $urandom % 3;
    o = $urandom % 3;
    m = 2'($urandom);
    s1 = f1 >= 3 && f1 <= 4 && md != 1 && md != 4 && !ok1;
    s2 = f2c >= 3 && f2c <= 4 && !ok2;
    fa = (s1 || s2) && rs != 2;
    seen = 0;
    drop = 0;
    seen2 = 0;
    first = 0;
    wr(CIC_OFS_CFG, 32'(md << 12 | rs << 8 | f2c << 4 | f1), r);
    wr(CIC_OFS_TIME, 32'(o << 16 | d), r);
    wr(CIC_OFS_MASK, {30'h0, m}, r);
    wr(CIC_OFS_IRQ, 32'h0000_0003, r);
    far.drive(1, ok1 ^ (f1 == 4));
    far.drive(2, ok2 ^ (f2c == 4));
    run_req <= 1'h1;
    for (n = 0; n < (d + o + 2) * TK + 10; n++) begin
      @(posedge clk);
      if (fany === 1'h1 && !seen) first = n;
      if (fany === 1'h1) seen = 1;
      if (seen && run === 1'h0) drop = 1;
      if (f2 === 1'h1) seen2 = 1;
    end
    chk("fault seen", fa, seen);
    chk("sw2 fault", s2 && rs != 2, seen2);
    if (fa) chk("not early", 1, first >= (d + o - 1) * TK);
    chk("stop on fault", fa && rs == 0, drop);
    rd(CIC_OFS_IRQ, v, r);
    chk("irq bits", {s2 && rs != 2, fa}, v);
    chk("irq line", |({s2 && rs != 2, fa} & m), irq);
    stop_req <= 1'h1;
    cyc(4);
    chk("stopped", 0, {run, fany});
    run_req <= 1'h0;
    stop_req <= 1'h0;
    wr(CIC_OFS_IRQ, 32'h0000_0003, r);
    cyc(1);
    chk("irq clear", 0, irq);
  endtask

  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    final_report;
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'h7f45));
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd(CIC_OFS_CFG, d, r);
    chk("cfg reset", CIC_CFG_RST, d);
    rd(CIC_OFS_TIME, d, r);
    chk("time reset", CIC_TIME_RST, d);
    rd(8'h20, d, r);
    chk("unmapped rresp", 2'h2, r);
    wr(CIC_OFS_STAT, 32'h0000_000F, r);
    chk("stat bresp", 2'h2, r);
    far.drive(1, 1'h1);
    cyc(4);
    chk("level run", 1, run);
    far.drive(1, 1'h0);
    cyc(4);
    chk("level stop", 0, run);
    wr(CIC_OFS_CFG, 32'h0000_0002, r);
    for (int i = 0; i < 2; i++) begin
      far.press(1);
      chk("pulse held", i, run);
      cyc(4);
      chk("pulse toggle", i == 0, run);
    end
    wr(CIC_OFS_CFG, 32'h0000_0052, r);
    far.drive(2, 1'h1);
    cyc(4);
    chk("host level", 1, cca);
    far.press(1);
    cyc(4);
    chk("host blocks", 0, run);
    far.drive(2, 1'h0);
    cyc(4);
    chk("host drop", 0, cca);
    wr(CIC_OFS_CFG, 32'h0000_0060, r);
    for (int i = 0; i < 2; i++) begin
      far.press(2);
      cyc(4);
      chk("host pulse", i == 0, cca);
    end
    wr(CIC_OFS_CFG, 32'h0000_0000, r);
    far.drive(1, 1'h1);
    cyc(4);
    chk("no function", 0, run);
    far.drive(2, 1'h1);
    wr(CIC_OFS_CFG, 32'h0000_0031, r);
    wr(CIC_OFS_IRQ, 32'h0000_0003, r);
    cyc(6);
    chk("run with switch", 1, run);
    rd(CIC_OFS_STAT, d, r);
    chk("stat word", 32'h0000_0001, d);
    far.drive(1, 1'h0);
    cyc(3);
    far.drive(2, 1'h0);
    cyc(30);
    rd(CIC_OFS_IRQ, d, r);
    chk("open after stop", 0, d);
    sup(0, 3, 0, 0, 1, 0);
    sup(0, 3, 1, 0, 1, 0);
    sup(0, 3, 2, 0, 1, 0);
    sup(0, 4, 0, 0, 1, 0);
    for (int i = 0; i < 5; i++) sup(3, 3, 0, i, 0, 1);
    sup(4, 3, 0, 2, 0, 0);
    final_report;
  end
endmodule // test_contact_input_control
